// File: verilog/sdli_pkg.sv
/*
 serial code load interface: shared constants and types.
 assumes a 25 MHz system clock that oversamples the serial link pins.
*/
// Summary of operation
// - data is sampled on each serial clock rising edge; only rising edges count bits.
// - sixteen-bit frame is the clock cycles while chip select is low.
// - a qualifying frame commits to the input register when chip select rises.
// - sixteen-bit frames with fewer than sixteen edges are discarded.
// - longer sixteen-bit frames use only the first sixteen bits.
// - sixteen-bit code is sent most significant bit first.
// - twenty-bit frame is the clock cycles while chip select is low, nominally 24.
// - twenty-bit frames with fewer than twenty-four edges are discarded.
// - longer twenty-bit frames use only the first twenty bits.
// - edges 1 to 20 carry the code msb first; edges 21 to 24 ignored.
// - load strobe falling edge moves input register into the output latch.
// - each accepted frame needs a processing latency before output update.
// - strobe falling after the latency updates the output at that edge.
// - strobe falling during the latency holds update until latency ends.
// - on reset the output latch clears to zero-scale.
package sdli_pkg;
    localparam int CLK_PERIOD_NS    = 40;
    localparam int LATENCY_NS       = 1210;
    localparam int LATENCY_CYC      = (LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRAME_EDGES_16   = 16;
    localparam int FRAME_EDGES_20   = 24;
    localparam int CODE_BITS_16     = 16;
    localparam int CODE_BITS_20     = 20;
    localparam logic [19:0] ZERO_SCALE = 20'h00000;

    typedef struct packed {
        logic csn;
        logic sclk;
        logic din;
        logic ldn;
    } sdli_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_BUSY    = 2'b01,
        ST_PENDING = 2'b10
    } sdli_state_t;
endpackage

// File: verilog/sdli_sync.sv
/*
 two-flop synchroniser for a group of link pins.
 assumes pins are asynchronous to clk_sys_i; reset value is the idle level.
*/
`timescale 1ns/1ns
`default_nettype none
module sdli_sync
    import sdli_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    input  wire sdli_pins_t pins_i,
    output var  sdli_pins_t pins_o
);
    // idle level: selects and strobe high, clock and data low
    localparam sdli_pins_t IDLE = '{csn: 1'b1, sclk: 1'b0, din: 1'b0, ldn: 1'b1};
    sdli_pins_t meta_r;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            meta_r <= IDLE;
            pins_o <= IDLE;
        end
        else
        begin
            meta_r <= pins_i;
            pins_o <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: verilog/sdli_core.sv
/*
 serial code load interface: shift register, frame qualification, input register,
 processing latency and output latch.
 assumes the host respects strobe and select ordering and clocks well below clk/4.
*/
`timescale 1ns/1ns
`default_nettype none
module sdli_core
    import sdli_pkg::*;
#(
    parameter bit WIDE20 = 1'b0
)
(
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic        chip_sel_n_i,
    input  wire logic        serial_clk_i,
    input  wire logic        serial_din_i,
    input  wire logic        output_load_strobe_n_i,
    output logic      [19:0] output_code_latch_o,
    output logic      [19:0] input_code_o,
    output logic             update_busy_o,
    output logic             update_pending_o
);
    localparam int FRAME_EDGES = WIDE20 ? FRAME_EDGES_20 : FRAME_EDGES_16;
    localparam int CODE_BITS   = WIDE20 ? CODE_BITS_20 : CODE_BITS_16;

    sdli_pins_t pins_s;
    sdli_pins_t pins_raw;
    logic       sclk_d_r;
    logic       csn_d_r;
    logic       ldn_d_r;
    logic [4:0] edge_cnt_r;
    logic [19:0] shift_r;
    logic [19:0] in_reg_r;
    logic [19:0] out_r;
    logic [5:0] lat_cnt_r;
    sdli_state_t state_r;
    sdli_state_t state_nxt;

    assign pins_raw = '{csn: chip_sel_n_i, sclk: serial_clk_i,
                        din: serial_din_i, ldn: output_load_strobe_n_i};

    sdli_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .pins_i    (pins_raw),
        .pins_o    (pins_s)
    );

    wire sclk_rise  = pins_s.sclk & ~sclk_d_r & ~pins_s.csn;
    wire cs_rise    = pins_s.csn & ~csn_d_r;
    wire ld_fall    = ~pins_s.ldn & ldn_d_r;
    wire take_bit   = sclk_rise && (edge_cnt_r < 5'(CODE_BITS));
    wire frame_ok   = cs_rise && (edge_cnt_r >= 5'(FRAME_EDGES));
    wire lat_done   = (lat_cnt_r == 6'd1);
    // falling edge during latency is remembered, so a short strobe is not lost
    wire do_load    = (state_r == ST_IDLE    && ld_fall)
                   || (state_r == ST_PENDING && lat_done)
                   || (state_r == ST_BUSY    && lat_done && ld_fall);

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            sclk_d_r <= 1'b0;
            csn_d_r  <= 1'b1;
            ldn_d_r  <= 1'b1;
        end
        else
        begin
            sclk_d_r <= pins_s.sclk;
            csn_d_r  <= pins_s.csn;
            ldn_d_r  <= pins_s.ldn;
        end
    end

    // counter saturates so overlong frames cannot wrap into a short count
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i || pins_s.csn)
            edge_cnt_r <= 5'h00;
        else if (sclk_rise && edge_cnt_r != 5'h1f)
            edge_cnt_r <= edge_cnt_r + 5'h01;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            shift_r <= ZERO_SCALE;
        else if (take_bit)
            shift_r <= {shift_r[18:0], pins_s.din};
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            in_reg_r <= ZERO_SCALE;
        else if (frame_ok)
            in_reg_r <= shift_r & ((20'h00001 << CODE_BITS) - 20'h00001);
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:    if (frame_ok) state_nxt = ST_BUSY;
            ST_BUSY:    if (lat_done) state_nxt = ST_IDLE;
                        else if (ld_fall) state_nxt = ST_PENDING;
            ST_PENDING: if (lat_done) state_nxt = ST_IDLE;
            default:    state_nxt = ST_IDLE;
        endcase
        if (frame_ok)
            state_nxt = ST_BUSY;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            state_r   <= ST_IDLE;
            lat_cnt_r <= 6'h00;
        end
        else
        begin
            state_r   <= state_nxt;
            // latency runs from the synchronised select edge, a few clocks after the pin
            if (frame_ok)
                lat_cnt_r <= 6'(LATENCY_CYC);
            else if (lat_cnt_r != 6'h00)
                lat_cnt_r <= lat_cnt_r - 6'h01;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            out_r <= ZERO_SCALE;
        else if (do_load)
            out_r <= in_reg_r;
    end

    assign output_code_latch_o = out_r;
    assign input_code_o        = in_reg_r;
    assign update_busy_o       = (state_r != ST_IDLE);
    assign update_pending_o    = (state_r == ST_PENDING);

    a_latch_steady: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !do_load |=> $stable(out_r))
        else $error("output latch changed without a load");
    a_short_drop: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cs_rise && edge_cnt_r < 5'(FRAME_EDGES)) |=> $stable(in_reg_r))
        else $error("short frame was committed");
    a_frame_busy: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        frame_ok |=> update_busy_o && lat_cnt_r == 6'(LATENCY_CYC))
        else $error("latency not started on commit");
    a_busy_load: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_r == ST_BUSY && ld_fall && !lat_done && !frame_ok) |=> update_pending_o)
        else $error("early strobe not held pending");
    a_idle_load: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_r == ST_IDLE && ld_fall) |=> out_r == $past(in_reg_r))
        else $error("idle strobe did not load");
    a_pend_apply: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        update_pending_o |-> ##[0:40] !update_pending_o)
        else $error("pending update never applied");
    a_edge_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (!sclk_rise && !pins_s.csn) |=> $stable(edge_cnt_r))
        else $error("bit count moved without rising edge");
    a_bit_limit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (sclk_rise && edge_cnt_r >= 5'(CODE_BITS)) |=> $stable(shift_r))
        else $error("bit past code width shifted in");

    // an early strobe and the end of its latency, shared by the pending checks
    sequence s_early_strobe;
        state_r == ST_BUSY && ld_fall && !lat_done && !frame_ok;
    endsequence
    sequence s_pend_release;
        state_r == ST_PENDING && lat_done;
    endsequence

    a_early_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        s_early_strobe |=> $stable(out_r))
        else $error("early strobe changed the output latch");

    a_pend_load: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        s_pend_release |=> out_r == $past(in_reg_r))
        else $error("pending update not applied at latency end");

    a_pend_source: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(update_pending_o) |-> $past(update_busy_o))
        else $error("pending entered outside latency");

    a_no_early: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_r == ST_BUSY && !lat_done) |=> $stable(out_r))
        else $error("output latch changed during latency");

    a_latency_end: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (lat_done && !frame_ok) |=> !update_busy_o)
        else $error("latency did not end on count");

    a_busy_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        update_busy_o |-> lat_cnt_r != 6'h00)
        else $error("busy without a running latency count");

    a_commit_code: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        frame_ok |=> in_reg_r[CODE_BITS-1:0] == $past(shift_r[CODE_BITS-1:0]))
        else $error("committed code differs from shifted bits");

    a_code_width: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (in_reg_r >> CODE_BITS) == 20'h00000)
        else $error("input register holds bits beyond code width");

    a_abort_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        pins_s.csn |=> edge_cnt_r == 5'h00)
        else $error("bit count kept while select high");

    a_edge_step: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (sclk_rise && edge_cnt_r != 5'h1f) |=> edge_cnt_r == $past(edge_cnt_r) + 5'h01)
        else $error("bit count did not step on rising edge");

    a_sample_bit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        take_bit |=> shift_r[0] == $past(pins_s.din))
        else $error("sampled bit not shifted in");

    // watches the reset itself, so it has no reset disable
    a_reset_zero: assert property (@(posedge clk_sys_i)
        sys_rst_i |=> out_r == ZERO_SCALE && in_reg_r == ZERO_SCALE)
        else $error("reset did not clear to zero-scale");
endmodule
`default_nettype wire

// File: testbench/sdli_host.sv
/*
 host model: drives select, serial clock, data and load strobe.
 assumes clk_sys_i at 40 ns; the link half period is four of its cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module sdli_host
    import sdli_pkg::*;
(
    input  wire logic       clk_sys_i,
    output var  sdli_pins_t pins_o
);
    // serial clock idles low and stands still between frames
    initial pins_o = '{csn: 1'b1, sclk: 1'b0, din: 1'b0, ldn: 1'b1};
    // 320 ns link period, far below the rated maximum rate
    task automatic half_link();
        repeat (4) @(negedge clk_sys_i);
    endtask
    // bits go out msb first from bit 23; n is the edge count (at most 24)
    task automatic send_frame(input logic [23:0] bits, input int n);
        pins_o.csn = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            pins_o.din = bits[23 - i];
            half_link();
            pins_o.sclk = 1'b1;
            half_link();
            pins_o.sclk = 1'b0;
        end
        half_link();
        pins_o.csn = 1'b1;
        // data no longer valid: show the inverse, not the last bit
        pins_o.din = ~pins_o.din;
        half_link();
    endtask
    task automatic pulse_load();
        pins_o.ldn = 1'b0;
        half_link();
        pins_o.ldn = 1'b1;
    endtask
endmodule
`default_nettype wire

// File: testbench/serial_dac_load_interface_test.sv
/*
 testbench: one host drives a 16-bit and a 20-bit core on shared pins.
 assumes 25 MHz clock, synchronous active-high reset, inputs set at falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module serial_dac_load_interface_test
    import sdli_pkg::*;
;
    logic        clk_sys_i;
    logic        sys_rst_i;
    sdli_pins_t  pins;
    logic [19:0] lat16, in16, lat20, in20;
    logic        busy16, pend16, busy20, pend20;
    int          miscompares;
    int          compares;

    sdli_host i_host (.clk_sys_i(clk_sys_i), .pins_o(pins));
    sdli_core #(.WIDE20(1'b0)) i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .chip_sel_n_i(pins.csn), .serial_clk_i(pins.sclk), .serial_din_i(pins.din),
        .output_load_strobe_n_i(pins.ldn), .output_code_latch_o(lat16),
        .input_code_o(in16), .update_busy_o(busy16), .update_pending_o(pend16));
    // the same 24-edge frame is overlong for the 16-bit core
    sdli_core #(.WIDE20(1'b1)) i_dut20 (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .chip_sel_n_i(pins.csn), .serial_clk_i(pins.sclk), .serial_din_i(pins.din),
        .output_load_strobe_n_i(pins.ldn), .output_code_latch_o(lat20),
        .input_code_o(in20), .update_busy_o(busy20), .update_pending_o(pend20));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_reset();
        check("lat16", lat16, 20'h00000);
        check("lat20", lat20, 20'h00000);
        check("in20", in20, 20'h00000);
        check("in16", in16, 20'h00000);
        check("busy16", {19'h00000, busy16}, 20'h00000);
        check("pend16", {19'h00000, pend16}, 20'h00000);
        check("busy20", {19'h00000, busy20}, 20'h00000);
        check("pend20", {19'h00000, pend20}, 20'h00000);
    endtask
    task automatic t_long_frame();
        i_host.send_frame(24'habcde5, 24);
        idle(8);
        check("in16", in16, 20'h0abcd);
        check("in20", in20, 20'habcde);
        check("lat16", lat16, 20'h00000);
        check("busy20", {19'h00000, busy20}, 20'h00001);
    endtask
    // strobe inside the latency must wait for it to end
    task automatic t_load_early();
        i_host.pulse_load();
        idle(4);
        check("pend16", {19'h00000, pend16}, 20'h00001);
        check("pend20", {19'h00000, pend20}, 20'h00001);
        check("lat20", lat20, 20'h00000);
        idle(30);
        check("lat16", lat16, 20'h0abcd);
        check("lat20", lat20, 20'habcde);
        check("busy16", {19'h00000, busy16}, 20'h00000);
    endtask
    task automatic t_short_frames();
        i_host.send_frame(24'h123400, 16);
        idle(8);
        check("in16", in16, 20'h01234);
        check("in20", in20, 20'habcde);
        idle(40);
        i_host.send_frame(24'h5a5a5a, 10);
        idle(8);
        check("in16", in16, 20'h01234);
        check("in20", in20, 20'habcde);
        i_host.pulse_load();
        idle(4);
        check("lat16", lat16, 20'h01234);
        check("lat20", lat20, 20'habcde);
    endtask
    // one edge short of each frame length, on both cores
    task automatic t_edge_ends();
        i_host.send_frame(24'hfedcba, 23);
        idle(8);
        check("in16", in16, 20'h0fedc);
        check("in20", in20, 20'habcde);
        check("lat16", lat16, 20'h01234);
        idle(40);
        i_host.send_frame(24'h2468ac, 15);
        idle(8);
        check("in16", in16, 20'h0fedc);
        check("busy16", {19'h00000, busy16}, 20'h00000);
    endtask
    // strobe after the latency loads a new code into both latches
    task automatic t_load_late();
        i_host.send_frame(24'h13579b, 24);
        idle(40);
        check("lat20", lat20, 20'habcde);
        check("busy20", {19'h00000, busy20}, 20'h00000);
        i_host.pulse_load();
        idle(4);
        check("lat16", lat16, 20'h01357);
        check("lat20", lat20, 20'h13579);
        check("pend20", {19'h00000, pend20}, 20'h00000);
    endtask
    task automatic t_mid_reset();
        sys_rst_i = 1'b1;
        idle(6);
        sys_rst_i = 1'b0;
        idle(4);
        check("lat16", lat16, 20'h00000);
        check("lat20", lat20, 20'h00000);
        check("in16", in16, 20'h00000);
        i_host.send_frame(24'h0f0f0f, 24);
        idle(8);
        check("in20", in20, 20'h0f0f0);
    endtask
    initial
    begin
        miscompares = 0;
        compares = 0;
        sys_rst_i = 1'b1;
        idle(6);
        sys_rst_i = 1'b0;
        idle(4);
        t_reset();
        t_long_frame();
        t_load_early();
        t_short_frames();
        t_edge_ends();
        t_load_late();
        t_mid_reset();
        tally_and_finish();
    end
    // about 1400 cycles expected; a hang is cut off well beyond that
    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
